// >>> hdl/line_trig_consts.vh
`ifndef LINE_TRIG_CONSTS_VH
`define LINE_TRIG_CONSTS_VH

// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_EXPOSURE 12'h004
`define OFF_PERIOD 12'h008
`define OFF_FORMAT 12'h00C
`define OFF_STATUS 12'h010
`define OFF_MEASURED 12'h014

// control fields
`define CTRL_SYNC_EN 0
`define CTRL_POL 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 3
`define CTRL_TARGET 4

// integration_control_choice encodings
`define MODE_OFF 2'h0
`define MODE_TIMED 2'h1
`define MODE_WIDTH 2'h2

// reset values; exposure and period in clock cycles, control as a register word
`define RST_EXPOSURE 32'h000003E8
`define RST_PERIOD 32'h00000FA0
`define RST_CTRL 32'h00000004

// format field positions: link speed, sample packing, region width
`define FMT_LINK_LO 0
`define FMT_LINK_HI 1
`define FMT_PACK_LO 2
`define FMT_PACK_HI 3
`define FMT_WIDTH_LO 16
`define FMT_WIDTH_HI 31

// timing
`define CLK_HZ 20000000
`define INIT_US 1000
`define INIT_CYCLES ((`INIT_US * (`CLK_HZ / 1000000)))
`define BLINK_MS 100
`define BLINK_CYCLES ((`BLINK_MS * (`CLK_HZ / 1000)))
`define LINE_CYCLE_FLOOR 32'h000000C8

`endif

// >>> hdl/edge_sync.v
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
	input wire clk_i,
	input wire rst_i,
	input wire pin_i,
	output reg level_o,
	output wire rise_o,
	output wire fall_o
);
	reg meta_q;
	reg prev_q;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= 1'b0;
			level_o <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= pin_i;
			level_o <= meta_q;
			prev_q <= level_o;
		end
	end

	assign rise_o = level_o & ~prev_q;
	assign fall_o = ~level_o & prev_q;
endmodule // edge_sync
`default_nettype wire

// >>> hdl/pulse_divider.v
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
	parameter [31:0] COUNT = 32'h00000002
) (
	input wire clk_i,
	input wire rst_i,
	output reg tick_o
);
	reg [31:0] cnt_q;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q <= 32'h00000000;
			tick_o <= 1'b0;
		end
		else if (cnt_q == COUNT - 32'h00000001)
		begin
			cnt_q <= 32'h00000000;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 32'h00000001;
			tick_o <= 1'b0;
		end
	end
endmodule // pulse_divider
`default_nettype wire

// >>> hdl/line_trigger_exposure_control.v
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "line_trig_consts.vh"

// Notes on behaviour
// - With external sync on and aimed at line start, each accepted trigger starts one line.
// - In timed and off exposure modes, the line starts on the configured trigger edge.
// - In timed mode each line integrates for exactly the programmed duration from line start, one cycle if it is zero.
// - In triggered timed mode, a duration longer than the trigger period is clamped to it.
// - In off mode the integration fills the whole line period.
// - In triggered pulse-length mode integration lasts while the trigger is at its active level.
// - With sync off, lines start internally at the set period, exposure capped to one period.
// - The internal line period is held above a floor set by packing, width and link speed.
// - During initialization after power-up the indicator shows amber.
// - When initialization completes the indicator turns green.
// - While triggers arrive in triggered mode the indicator blinks green at a fixed rate.
module line_trigger_exposure_control #(
	parameter [31:0] INIT_COUNT = `INIT_CYCLES,
	parameter [31:0] BLINK_COUNT = `BLINK_CYCLES
) (
	input wire clk_i,
	input wire rst_i,
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output reg [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	input wire trigger_pin_i,
	output reg per_line_begin_event_o,
	output reg integrating_o,
	output reg led_green_o,
	output reg led_amber_o
);
	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	reg [31:0] ctrl_q;
	reg [31:0] exposure_q;
	reg [31:0] period_q;
	reg [31:0] format_q;
	reg wr_pend_q;
	reg [11:0] wr_addr_q;
	reg [31:0] trig_period_q;
	reg init_done_q;

	wire external_line_sync_enable = ctrl_q[`CTRL_SYNC_EN];
	wire trigger_polarity_choice = ctrl_q[`CTRL_POL];
	wire [1:0] integration_control_choice = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
	wire trigger_target_choice = ctrl_q[`CTRL_TARGET];
	wire addr_phase = hsel_i & hready_i & htrans_i[1];

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	function [31:0] reg_read;
		input [11:0] a;
		input [31:0] status;
		begin
			case (a)
				`OFF_CTRL: reg_read = ctrl_q;
				`OFF_EXPOSURE: reg_read = exposure_q;
				`OFF_PERIOD: reg_read = period_q;
				`OFF_FORMAT: reg_read = format_q;
				`OFF_STATUS: reg_read = status;
				`OFF_MEASURED: reg_read = trig_period_q;
				default: reg_read = 32'h00000000;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// line rate floor
	// ------------------------------------------------------------
	// floor grows with bytes per line and shrinks with link speed
	wire [1:0] link_speed = format_q[`FMT_LINK_HI:`FMT_LINK_LO];
	wire [1:0] packing = format_q[`FMT_PACK_HI:`FMT_PACK_LO];
	wire [15:0] roi_width = format_q[`FMT_WIDTH_HI:`FMT_WIDTH_LO];
	wire [31:0] bytes_line = {14'h0000, roi_width, 2'h0} >>
		(2'h2 - ((packing > 2'h2) ? 2'h2 : packing));
	wire [31:0] xfer_cycles = bytes_line >> (3'h4 + {1'b0, link_speed});
	wire [31:0] floor_cycles = (xfer_cycles > `LINE_CYCLE_FLOOR) ?
		xfer_cycles : `LINE_CYCLE_FLOOR;
	wire [31:0] period_eff = (period_q < floor_cycles) ?
		floor_cycles : period_q;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= `RST_CTRL;
			exposure_q <= `RST_EXPOSURE;
			period_q <= `RST_PERIOD;
			format_q <= 32'h00000000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end
		else
		begin
			wr_pend_q <= addr_phase & hwrite_i;
			if (addr_phase)
				wr_addr_q <= haddr_i[11:0];
			if (wr_pend_q)
			begin
				case (wr_addr_q)
					`OFF_CTRL: ctrl_q <= {27'h0000000, hwdata_i[4:0]};
					`OFF_EXPOSURE: exposure_q <= hwdata_i;
					`OFF_PERIOD: period_q <= hwdata_i;
					`OFF_FORMAT: format_q <= hwdata_i;
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// trigger input
	// ------------------------------------------------------------
	wire trig_level;
	wire trig_rise;
	wire trig_fall;

	edge_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(trigger_pin_i),
		.level_o(trig_level),
		.rise_o(trig_rise),
		.fall_o(trig_fall)
	);

	// polarity bit: 0 = low_to_high_edge / active_high_level
	function by_polarity;
		input pol;
		input pos_sel;
		input neg_sel;
		begin
			by_polarity = pol ? neg_sel : pos_sel;
		end
	endfunction

	wire trig_active = by_polarity(trigger_polarity_choice, trig_level,
		~trig_level);
	wire trig_start = by_polarity(trigger_polarity_choice, trig_rise,
		trig_fall);
	wire trig_end = by_polarity(trigger_polarity_choice, trig_fall,
		trig_rise);
	wire width_mode = (integration_control_choice == `MODE_WIDTH) &
		external_line_sync_enable;
	wire timed_mode = (integration_control_choice == `MODE_TIMED) |
		((integration_control_choice == `MODE_WIDTH) &
		~external_line_sync_enable);

	// ------------------------------------------------------------
	// line sequencing
	// ------------------------------------------------------------
	reg [31:0] line_cnt_q;
	reg [31:0] since_trig_q;
	reg [31:0] exp_cnt_q;
	reg [31:0] exp_len_q;
	reg trig_seen_q;

	wire ext_start = external_line_sync_enable & trigger_target_choice &
		init_done_q & trig_start;
	wire int_start = ~external_line_sync_enable & init_done_q &
		(line_cnt_q >= period_eff - 32'h00000001);
	wire line_start = ext_start | int_start;
	wire [31:0] cur_period = external_line_sync_enable ?
		(trig_seen_q ? trig_period_q : period_eff) : period_eff;
	wire [31:0] timed_len = (exposure_q > cur_period) ?
		cur_period : exposure_q;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			line_cnt_q <= 32'h00000000;
			exp_cnt_q <= 32'h00000000;
			exp_len_q <= 32'h00000000;
			integrating_o <= 1'b0;
			per_line_begin_event_o <= 1'b0;
		end
		else
		begin
			per_line_begin_event_o <= line_start;
			if (line_start | external_line_sync_enable)
				line_cnt_q <= 32'h00000000;
			else
				line_cnt_q <= line_cnt_q + 32'h00000001;
			if (width_mode)
			begin
				exp_cnt_q <= 32'h00000000;
				if (ext_start | (init_done_q & trig_active & trigger_target_choice))
					integrating_o <= 1'b1;
				else if (trig_end | ~trig_active)
					integrating_o <= 1'b0;
			end
			else if (line_start)
			begin
				exp_len_q <= timed_mode ? timed_len : cur_period;
				exp_cnt_q <= 32'h00000001;
				integrating_o <= 1'b1;
			end
			else if (integrating_o)
			begin
				// length zero still shows one cycle of integration
				if (exp_cnt_q >= exp_len_q)
					integrating_o <= 1'b0;
				else
					exp_cnt_q <= exp_cnt_q + 32'h00000001;
			end
		end
	end

	// ------------------------------------------------------------
	// trigger period measurement
	// ------------------------------------------------------------
	// zero means no trigger yet since sync was switched on, so the
	// gap left by an earlier run is never taken as a period
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			since_trig_q <= 32'h00000000;
			trig_period_q <= 32'h00000000;
			trig_seen_q <= 1'b0;
		end
		else if (~external_line_sync_enable)
		begin
			since_trig_q <= 32'h00000000;
			trig_seen_q <= 1'b0;
		end
		else if (ext_start)
		begin
			since_trig_q <= 32'h00000001;
			if (since_trig_q != 32'h00000000)
			begin
				trig_period_q <= since_trig_q;
				trig_seen_q <= 1'b1;
			end
		end
		// saturates: a stalled trigger keeps the longest period
		else if ((since_trig_q != 32'h00000000) &
			(since_trig_q != 32'hFFFFFFFF))
			since_trig_q <= since_trig_q + 32'h00000001;
	end

	// ------------------------------------------------------------
	// indicator
	// ------------------------------------------------------------
	reg [31:0] init_cnt_q;
	reg blink_q;
	reg recent_q;
	wire blink_tick;
	localparam [1:0] IND_INIT = 2'h0;
	localparam [1:0] IND_SOLID = 2'h1;
	localparam [1:0] IND_BLINK = 2'h2;
	reg [1:0] ind_state_q;
	reg [1:0] ind_state_d;

	// blink uses its own divider, not the trigger rate
	pulse_divider #(
		.COUNT(BLINK_COUNT)
	) u_blink (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(blink_tick)
	);

	// ------------------------------------------------------------
	// indicator state
	// ------------------------------------------------------------
	always @*
	begin
		ind_state_d = ind_state_q;
		case (ind_state_q)
			IND_INIT:
				if (init_done_q)
					ind_state_d = IND_SOLID;
			IND_SOLID:
				if (external_line_sync_enable & recent_q)
					ind_state_d = IND_BLINK;
			IND_BLINK:
				if (~external_line_sync_enable | ~recent_q)
					ind_state_d = IND_SOLID;
			default:
				ind_state_d = IND_INIT;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			init_cnt_q <= 32'h00000000;
			init_done_q <= 1'b0;
			blink_q <= 1'b0;
			recent_q <= 1'b0;
			led_green_o <= 1'b0;
			led_amber_o <= 1'b1;
			ind_state_q <= IND_INIT;
		end
		else
		begin
			if (~init_done_q)
			begin
				init_cnt_q <= init_cnt_q + 32'h00000001;
				if (init_cnt_q >= INIT_COUNT - 32'h00000001)
					init_done_q <= 1'b1;
			end
			// a trigger within the last blink slot keeps blinking alive
			if (ext_start)
				recent_q <= 1'b1;
			else if (blink_tick & ~blink_q)
				recent_q <= 1'b0;
			if (blink_tick)
				blink_q <= ~blink_q;
			ind_state_q <= ind_state_d;
			led_amber_o <= (ind_state_d == IND_INIT);
			led_green_o <= (ind_state_d == IND_SOLID) |
				((ind_state_d == IND_BLINK) & blink_q);
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	wire [31:0] status_word = {27'h0000000, trig_seen_q, led_green_o,
		integrating_o, trig_level, init_done_q};

	always @(posedge clk_i)
	begin
		if (rst_i)
			hrdata_o <= 32'h00000000;
		else if (addr_phase & ~hwrite_i)
			hrdata_o <= reg_read(haddr_i[11:0], status_word);
	end
endmodule // line_trigger_exposure_control
`default_nettype wire

// >>> testbench/line_trigger_exposure_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module line_trig_checker #(
	parameter [31:0] INIT_COUNT = 32'h00000014,
	parameter [31:0] BLINK_COUNT = 32'h00000008
) (
	input wire clk_i,
	input wire rst_i,
	input wire hreadyout_o,
	input wire hresp_o,
	input wire per_line_begin_event_o,
	input wire integrating_o,
	input wire led_green_o,
	input wire led_amber_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// indicator and line timing
	// ----------------------------------------
	AST_INIT_AMBER: assert property (
		$fell(rst_i) |-> (led_amber_o && !led_green_o)[*8])
		else $error("amber not held at start of init");
	AST_LED_EXCL: assert property (
		!(led_amber_o && led_green_o))
		else $error("amber and green lit together");
	AST_AMBER_TO_GREEN: assert property (
		$fell(led_amber_o) |-> led_green_o)
		else $error("green not lit when init ends");
	AST_AMBER_STAYS_OFF: assert property (
		!led_amber_o |=> !led_amber_o)
		else $error("amber came back after init");
	AST_EVENT_PULSE: assert property (
		per_line_begin_event_o |=> !per_line_begin_event_o)
		else $error("line start longer than one cycle");
	AST_EVENT_INTEG: assert property (
		per_line_begin_event_o |-> integrating_o)
		else $error("line start without integration");
	AST_INTEG_CAUSE: assert property (
		$rose(integrating_o) |-> per_line_begin_event_o)
		else $error("integration began without line start");
	// zero-wait slave: a stall here would hang every master
	AST_BUS_OK: assert property (
		hreadyout_o && !hresp_o)
		else $error("bus stalled or errored");
endmodule // line_trig_checker
`default_nettype wire

// >>> testbench/trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module trig_src (
	input wire logic clk_i,
	output logic pin_o
);
	initial pin_o = 1'b0;
	task automatic park(input logic lv);
		@(posedge clk_i);
		pin_o <= lv;
	endtask
	// pulses of hi cycles at act level, one every per cycles
	task automatic train(input int n, input int hi, input int per,
		input logic act);
		repeat (n)
		begin
			@(posedge clk_i);
			pin_o <= act;
			repeat (hi) @(posedge clk_i);
			pin_o <= !act;
			repeat (per - hi - 1) @(posedge clk_i);
		end
	endtask
endmodule // trig_src
`default_nettype wire

// >>> testbench/line_trigger_exposure_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "line_trig_consts.vh"
module line_trigger_exposure_control_test;
	localparam [31:0] INIT_N = 32'h00000014;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h00000000;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h00000000;
	wire [31:0] hrdata_o;
	wire hreadyout_o, hresp_o, pin, line_ev, integ, green, amber;
	int miscompares = 0;
	int n_checks = 0;
	int g, l, g2, l2;
	logic dark;
	logic [31:0] rd;
	always #25 clk_i = ~clk_i;
	trig_src u_src (.clk_i(clk_i), .pin_o(pin));
	line_trigger_exposure_control #(.INIT_COUNT(INIT_N),
		.BLINK_COUNT(32'h00000008)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .trigger_pin_i(pin),
		.per_line_begin_event_o(line_ev), .integrating_o(integ),
		.led_green_o(green), .led_amber_o(amber));
	always @(posedge clk_i)
		if (green !== 1'b1)
			dark <= 1'b1;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		hwrite_i <= w;
		htrans_i <= 2'h2;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		r = hrdata_o;
	endtask
	// park via sync-off so a level change cannot start a stray line
	task automatic setup(input logic [31:0] c, input logic lv);
		bus(1'b1, `OFF_CTRL, 32'h00000004, rd);
		u_src.park(lv);
		bus(1'b1, `OFF_CTRL, c, rd);
		repeat (40) @(posedge clk_i);
	endtask
	task automatic wait_ev(inout int n);
		while (line_ev !== 1'b1 && n < 5000)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask
	// cycles integration still runs once a trigger train has ended
	task automatic tail(output int n);
		n = 0;
		#1;
		while (integ === 1'b1 && n < 5000)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask
	task automatic line(output int gp, output int ln);
		gp = 0;
		ln = 0;
		wait_ev(gp);
		while (integ === 1'b1 && ln < 5000)
		begin
			@(posedge clk_i);
			#1;
			ln++;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_init;
		chk("amber", 1, amber);
		chk("green", 0, green);
		repeat (INIT_N + 4) @(posedge clk_i);
		#1;
		chk("amber", 0, amber);
		chk("green", 1, green);
		$display("end init");
	endtask
	task automatic t_regs;
		bus(1'b0, `OFF_CTRL, 32'h00000000, rd);
		chk("ctrl", `RST_CTRL, rd);
		bus(1'b0, `OFF_EXPOSURE, 32'h00000000, rd);
		chk("exposure", `RST_EXPOSURE, rd);
		bus(1'b0, `OFF_PERIOD, 32'h00000000, rd);
		chk("period", `RST_PERIOD, rd);
		bus(1'b1, 32'h00000040, 32'hFFFFFFFF, rd);
		bus(1'b0, 32'h00000040, 32'h00000000, rd);
		chk("unmapped", 0, rd);
		bus(1'b1, `OFF_EXPOSURE, 32'h0000001E, rd);
		bus(1'b0, `OFF_EXPOSURE, 32'h00000000, rd);
		chk("exposure", 32'h0000001E, rd);
		$display("end regs");
	endtask
	task automatic t_ext;
		for (int p = 0; p < 2; p++)
		begin
			setup(32'h00000015 | (p << 1), p[0]);
			dark = 1'b0;
			fork
				u_src.train(4, 10, 100, !p[0]);
			join_none
			line(g, l);
			chk("edge lag", 1, g < 8);
			line(g2, l2);
			chk("timed len", 30, l2);
			chk("period", 100, l + g2);
			wait fork;
			chk("blink", 1, dark);
			bus(1'b0, `OFF_MEASURED, 32'h00000000, rd);
			chk("measured", 100, rd);
		end
		$display("end ext");
	endtask
	task automatic t_clamp;
		setup(32'h00000015, 1'b0);
		bus(1'b1, `OFF_EXPOSURE, 32'h000001F4, rd);
		fork
			u_src.train(8, 10, 100, 1'b1);
		join_none
		// lines overlap, so only the tail after the last start shows
		// whether the long setting was cut to the trigger period
		wait fork;
		tail(l);
		chk("clamped", 1, l > 0 && l < 10);
		$display("end clamp");
	endtask
	task automatic t_width;
		for (int p = 0; p < 2; p++)
		begin
			setup(32'h00000019 | (p << 1), p[0]);
			fork
				u_src.train(2, 40, 100, !p[0]);
			join_none
			line(g, l);
			chk("width len", 40, l);
			wait fork;
		end
		$display("end width");
	endtask
	task automatic t_off;
		setup(32'h00000011, 1'b0);
		fork
			u_src.train(4, 10, 120, 1'b1);
		join_none
		g = 0;
		wait_ev(g);
		@(posedge clk_i);
		#1;
		wait_ev(g);
		l = 0;
		repeat (100)
		begin
			@(posedge clk_i);
			#1;
			if (integ === 1'b1)
				l++;
		end
		chk("full line", 100, l);
		wait fork;
		tail(l);
		chk("off tail", 1, l > 0 && l < 10);
		$display("end off");
	endtask
	task automatic t_int;
		setup(32'h00000004, 1'b0);
		bus(1'b1, `OFF_EXPOSURE, 32'h00000032, rd);
		bus(1'b1, `OFF_PERIOD, 32'h00000190, rd);
		line(g, l);
		line(g2, l2);
		chk("int len", 50, l2);
		chk("int period", 400, l + g2);
		bus(1'b1, `OFF_CTRL, 32'h00000008, rd);
		line(g, l);
		line(g2, l2);
		chk("fallback len", 50, l2);
		bus(1'b1, `OFF_PERIOD, 32'h00000064, rd);
		bus(1'b1, `OFF_FORMAT, 32'h00000000, rd);
		line(g, l);
		line(g2, l2);
		chk("floor", 200, l + g2);
		bus(1'b1, `OFF_FORMAT, 32'h10000008, rd);
		line(g, l);
		line(g2, l2);
		chk("wide floor", 1024, l + g2);
		$display("end int");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		close_out();
	end
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		t_init();
		t_regs();
		t_ext();
		t_clamp();
		t_width();
		t_off();
		t_int();
		close_out();
	end
endmodule // line_trigger_exposure_control_test
bind line_trigger_exposure_control line_trig_checker #(
	.INIT_COUNT(INIT_COUNT), .BLINK_COUNT(BLINK_COUNT)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .per_line_begin_event_o(per_line_begin_event_o),
	.integrating_o(integrating_o), .led_green_o(led_green_o),
	.led_amber_o(led_amber_o));
`default_nettype wire
